//--- hdl/irq_pin_driver.sv
// one interrupt pin: latch, pulse or real-time shaping and polarity
`timescale 1ns/1ps
`default_nettype none
module irq_pin_driver #(
    parameter int COUNT_W = irq_router_pkg::COUNT_W,
    parameter int SHORT_CYCLES = irq_router_pkg::PULSE_SHORT_CYCLES,
    parameter int LONG_CYCLES = irq_router_pkg::PULSE_LONG_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    irq_pin_if.pin cfg,
    output logic pin_o
);
    logic event_q;
    logic held;
    logic [COUNT_W-1:0] count;
    logic trigger;
    logic active;

    assign trigger = cfg.event_level & ~event_q;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            event_q <= 1'b0;
        end else begin
            event_q <= cfg.event_level;
        end
    end

    // latched hold: a new trigger beats a simultaneous clear
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            held <= 1'b0;
        end else if (trigger) begin
            held <= 1'b1;
        end else if (cfg.clear) begin
            held <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            count <= '0;
        end else if (trigger &&
                     cfg.mode == irq_router_pkg::MODE_PULSE_SHORT) begin
            count <= COUNT_W'(SHORT_CYCLES);
        end else if (trigger &&
                     cfg.mode == irq_router_pkg::MODE_PULSE_LONG) begin
            count <= COUNT_W'(LONG_CYCLES);
        end else if (count != '0) begin
            count <= count - 1'b1;
        end
    end

    always_comb begin
        case (cfg.mode)
            irq_router_pkg::MODE_LATCHED: active = held;
            irq_router_pkg::MODE_PULSE_SHORT: active = count != '0;
            irq_router_pkg::MODE_PULSE_LONG: active = count != '0;
            irq_router_pkg::MODE_REAL_TIME: active = cfg.event_level;
            default: active = 1'b0;
        endcase
    end

    // disabled pin rests at the inactive level of its own polarity
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pin_o <= 1'b0;
        end else if (cfg.enable && active) begin
            pin_o <= cfg.polarity;
        end else begin
            pin_o <= ~cfg.polarity;
        end
    end
endmodule // irq_pin_driver
`default_nettype wire

//--- hdl/irq_pin_router.sv
// interrupt source masking, routing and pin control registers
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - a disabled pin holds its inactive level; enabled pin follows sources.
// - polarity bit picks asserted level: 0 drives low, 1 drives high.
// - latch mode 00 holds the pin asserted until the source is cleared.
// - latch mode 01 asserts a triggered pin for about 40 us.
// - latch mode 10 asserts a triggered pin for about 160 us.
// - latch mode 11 follows the live interrupt condition.
// - first pin routing, one bit per source, resets to all ones.
// - second pin routing, same layout, resets to all zeros.
// - enable mask per source, resets to buffer full and watermark only.
// - direction mask qualifies wake-up and back-to-sleep per axis sign.
// - pin control holds enable, polarity, mode for second then first pin.
// - reading the second release location clears its sources, returns zero.
module irq_pin_router #(
    parameter int SHORT_CYCLES = irq_router_pkg::PULSE_SHORT_CYCLES,
    parameter int LONG_CYCLES = irq_router_pkg::PULSE_LONG_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    output logic [7:0] reg_rdata_o,
    input wire logic buffer_full_i,
    input wire logic watermark_i,
    input wire logic [5:0] wakeup_dir_i,
    input wire logic [5:0] backsleep_dir_i,
    input wire logic aux_two_ready_i,
    input wire logic aux_one_ready_i,
    input wire logic accel_temp_ready_i,
    input wire logic gyro_ready_i,
    input wire logic first_src_clear_i,
    output logic second_src_clear_o,
    output logic irq_pin_first_o,
    output logic irq_pin_second_o
);
    logic [7:0] interrupt_pin_control;
    logic [7:0] first_pin_source_routing;
    logic [7:0] second_pin_source_routing;
    logic [7:0] interrupt_enable_mask;
    logic [7:0] motion_direction_mask;
    logic [7:0] sources;
    logic [7:0] qualified;
    logic [7:0] next_rdata;
    logic wakeup_event;
    logic backsleep_event;
    logic write_pin_control;
    logic write_first_routing;
    logic write_second_routing;
    logic write_enable_mask;
    logic write_motion_mask;
    logic second_release_read;

    irq_pin_if first_cfg ();
    irq_pin_if second_cfg ();

    // motion events only count on enabled axis directions
    assign wakeup_event =
        |(wakeup_dir_i & motion_direction_mask[5:0]);
    assign backsleep_event =
        |(backsleep_dir_i & motion_direction_mask[5:0]);

    always_comb begin
        sources = 8'h00;
        sources[irq_router_pkg::SRC_BUFFER_FULL] = buffer_full_i;
        sources[irq_router_pkg::SRC_WATERMARK] = watermark_i;
        sources[irq_router_pkg::SRC_WAKEUP] = wakeup_event;
        sources[irq_router_pkg::SRC_BACKSLEEP] = backsleep_event;
        sources[irq_router_pkg::SRC_AUX_TWO] = aux_two_ready_i;
        sources[irq_router_pkg::SRC_AUX_ONE] = aux_one_ready_i;
        sources[irq_router_pkg::SRC_ACCEL_TEMP] = accel_temp_ready_i;
        sources[irq_router_pkg::SRC_GYRO] = gyro_ready_i;
    end

    assign qualified = sources & interrupt_enable_mask;

    // register bank: one write strobe per location
    assign write_pin_control = reg_write_i &&
        reg_addr_i == irq_router_pkg::OFS_PIN_CONTROL;
    assign write_first_routing = reg_write_i &&
        reg_addr_i == irq_router_pkg::OFS_FIRST_ROUTING;
    assign write_second_routing = reg_write_i &&
        reg_addr_i == irq_router_pkg::OFS_SECOND_ROUTING;
    assign write_enable_mask = reg_write_i &&
        reg_addr_i == irq_router_pkg::OFS_ENABLE_MASK;
    assign write_motion_mask = reg_write_i &&
        reg_addr_i == irq_router_pkg::OFS_MOTION_MASK;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            interrupt_pin_control <= irq_router_pkg::RST_PIN_CONTROL;
        end else if (write_pin_control) begin
            interrupt_pin_control <= reg_wdata_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            first_pin_source_routing <= irq_router_pkg::RST_FIRST_ROUTING;
        end else if (write_first_routing) begin
            first_pin_source_routing <= reg_wdata_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            second_pin_source_routing <= irq_router_pkg::RST_SECOND_ROUTING;
        end else if (write_second_routing) begin
            second_pin_source_routing <= reg_wdata_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            interrupt_enable_mask <= irq_router_pkg::RST_ENABLE_MASK;
        end else if (write_enable_mask) begin
            interrupt_enable_mask <= reg_wdata_i;
        end
    end

    // reserved top bits stay zero
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            motion_direction_mask <= irq_router_pkg::RST_MOTION_MASK;
        end else if (write_motion_mask) begin
            motion_direction_mask <=
                reg_wdata_i & irq_router_pkg::MOTION_MASK_BITS;
        end
    end

    assign second_release_read = reg_read_i &&
        reg_addr_i == irq_router_pkg::OFS_SECOND_RELEASE;

    // release read yields zero and a one-cycle clear to the source logic
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            second_src_clear_o <= 1'b0;
        end else begin
            second_src_clear_o <= second_release_read;
        end
    end

    // unmapped locations and the release location read as zero
    always_comb begin
        next_rdata = 8'h00;
        case (reg_addr_i)
            irq_router_pkg::OFS_PIN_CONTROL:
                next_rdata = interrupt_pin_control;
            irq_router_pkg::OFS_FIRST_ROUTING:
                next_rdata = first_pin_source_routing;
            irq_router_pkg::OFS_SECOND_ROUTING:
                next_rdata = second_pin_source_routing;
            irq_router_pkg::OFS_ENABLE_MASK:
                next_rdata = interrupt_enable_mask;
            irq_router_pkg::OFS_MOTION_MASK:
                next_rdata = motion_direction_mask;
            irq_router_pkg::OFS_SECOND_RELEASE:
                next_rdata = 8'h00;
            default:
                next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_read_i) begin
            reg_rdata_o <= next_rdata;
        end
    end

    // each pin takes its own enable, polarity and mode fields
    assign first_cfg.enable =
        interrupt_pin_control[irq_router_pkg::FIRST_ENABLE_BIT];
    assign first_cfg.polarity =
        interrupt_pin_control[irq_router_pkg::FIRST_POLARITY_BIT];
    assign first_cfg.mode =
        interrupt_pin_control[irq_router_pkg::FIRST_MODE_LSB +: 2];
    assign first_cfg.event_level =
        |(qualified & first_pin_source_routing);
    assign first_cfg.clear = first_src_clear_i;

    assign second_cfg.enable =
        interrupt_pin_control[irq_router_pkg::SECOND_ENABLE_BIT];
    assign second_cfg.polarity =
        interrupt_pin_control[irq_router_pkg::SECOND_POLARITY_BIT];
    assign second_cfg.mode =
        interrupt_pin_control[irq_router_pkg::SECOND_MODE_LSB +: 2];
    assign second_cfg.event_level =
        |(qualified & second_pin_source_routing);
    assign second_cfg.clear = second_release_read;

    // both pins share one shaping design
    irq_pin_driver #(
        .COUNT_W(irq_router_pkg::COUNT_W),
        .SHORT_CYCLES(SHORT_CYCLES),
        .LONG_CYCLES(LONG_CYCLES)
    ) first_driver (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .cfg(first_cfg),
        .pin_o(irq_pin_first_o)
    );

    irq_pin_driver #(
        .COUNT_W(irq_router_pkg::COUNT_W),
        .SHORT_CYCLES(SHORT_CYCLES),
        .LONG_CYCLES(LONG_CYCLES)
    ) second_driver (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .cfg(second_cfg),
        .pin_o(irq_pin_second_o)
    );
endmodule // irq_pin_router
`default_nettype wire

//--- shared/irq_pin_if.sv
// configuration and event bundle between router and one pin driver
`timescale 1ns/1ps
`default_nettype none
interface irq_pin_if;
    logic enable;
    logic polarity;
    logic [1:0] mode;
    logic event_level;
    logic clear;
    modport ctl (output enable, polarity, mode, event_level, clear);
    modport pin (input enable, polarity, mode, event_level, clear);
endinterface
`default_nettype wire

//--- shared/irq_router_pkg.sv
// constants for the interrupt pin router
package irq_router_pkg;
    localparam logic [7:0] OFS_PIN_CONTROL = 8'h45;
    localparam logic [7:0] OFS_FIRST_ROUTING = 8'h46;
    localparam logic [7:0] OFS_SECOND_ROUTING = 8'h47;
    localparam logic [7:0] OFS_ENABLE_MASK = 8'h48;
    localparam logic [7:0] OFS_MOTION_MASK = 8'h49;
    localparam logic [7:0] OFS_SECOND_RELEASE = 8'h3d;

    localparam logic [7:0] RST_PIN_CONTROL = 8'h44;
    localparam logic [7:0] RST_FIRST_ROUTING = 8'hff;
    localparam logic [7:0] RST_SECOND_ROUTING = 8'h00;
    localparam logic [7:0] RST_ENABLE_MASK = 8'hc0;
    localparam logic [7:0] RST_MOTION_MASK = 8'h3f;
    localparam logic [7:0] MOTION_MASK_BITS = 8'h3f;

    // pin control field positions
    localparam int SECOND_ENABLE_BIT = 7;
    localparam int SECOND_POLARITY_BIT = 6;
    localparam int SECOND_MODE_LSB = 4;
    localparam int FIRST_ENABLE_BIT = 3;
    localparam int FIRST_POLARITY_BIT = 2;
    localparam int FIRST_MODE_LSB = 0;

    // source bit positions, shared by routing and enable mask
    localparam int SRC_BUFFER_FULL = 7;
    localparam int SRC_WATERMARK = 6;
    localparam int SRC_WAKEUP = 5;
    localparam int SRC_BACKSLEEP = 4;
    localparam int SRC_AUX_TWO = 3;
    localparam int SRC_AUX_ONE = 2;
    localparam int SRC_ACCEL_TEMP = 1;
    localparam int SRC_GYRO = 0;

    localparam logic [1:0] MODE_LATCHED = 2'h0;
    localparam logic [1:0] MODE_PULSE_SHORT = 2'h1;
    localparam logic [1:0] MODE_PULSE_LONG = 2'h2;
    localparam logic [1:0] MODE_REAL_TIME = 2'h3;

    localparam int CLK_MHZ = 100;
    localparam int PULSE_SHORT_US = 40;
    localparam int PULSE_LONG_US = 160;
    localparam int PULSE_SHORT_CYCLES = PULSE_SHORT_US * CLK_MHZ;
    localparam int PULSE_LONG_CYCLES = PULSE_LONG_US * CLK_MHZ;
    localparam int COUNT_W = 16;
endpackage

//--- tb/irq_host_sampler.sv
// host side sampler counting asserted cycles of one interrupt pin
`timescale 1ns/1ps
`default_nettype none
module irq_host_sampler (
    input wire logic clk_i,
    input wire logic pin_i,
    input wire logic idle_i,
    input wire logic clr_i,
    output logic [15:0] busy_o
);
    always_ff @(posedge clk_i) begin
        if (clr_i) begin
            busy_o <= 16'h0000;
        end else if (pin_i != idle_i) begin
            busy_o <= busy_o + 16'h0001;
        end
    end
endmodule // irq_host_sampler
`default_nettype wire

//--- tb/irq_pin_router_monitor.sv
// port assertions for the interrupt pin router
`timescale 1ns/1ps
`default_nettype none
module irq_router_monitor #(
    parameter int SHORT_CYCLES = 4000,
    parameter int LONG_CYCLES = 16000
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic first_src_clear_i,
    input wire logic second_src_clear_o,
    input wire logic irq_pin_first_o,
    input wire logic irq_pin_second_o
);
    logic [7:0] ctl, r1, r2, msk, mm, exp_rd;
    logic [15:0] hi1;
    logic rel;
    assign rel = reg_read_i && (reg_addr_i == 8'h3d);
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctl <= 8'h44;
            r1 <= 8'hff;
            r2 <= 8'h00;
            msk <= 8'hc0;
            mm <= 8'h3f;
        end else if (reg_write_i) begin
            case (reg_addr_i)
                8'h45: ctl <= reg_wdata_i;
                8'h46: r1 <= reg_wdata_i;
                8'h47: r2 <= reg_wdata_i;
                8'h48: msk <= reg_wdata_i;
                8'h49: mm <= reg_wdata_i & 8'h3f;
                default: ;
            endcase
        end
    end
    always_comb begin
        case (reg_addr_i)
            8'h45: exp_rd = ctl;
            8'h46: exp_rd = r1;
            8'h47: exp_rd = r2;
            8'h48: exp_rd = msk;
            8'h49: exp_rd = mm;
            default: exp_rd = 8'h00;
        endcase
    end
    // consecutive high cycles of the first pin
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            hi1 <= 16'h0000;
        end else begin
            hi1 <= irq_pin_first_o ? hi1 + 16'h0001 : 16'h0000;
        end
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);
    chk_release_zero: assert property (rel |=> reg_rdata_o == 8'h00)
        else $error("release read not zero");
    chk_release_pulse: assert property (
        second_src_clear_o == $past(rel))
        else $error("release pulse wrong");
    chk_read_back: assert property (
        reg_read_i && !reg_write_i |=> reg_rdata_o == $past(exp_rd))
        else $error("read data wrong");
    chk_idle_first: assert property (
        !ctl[3] && $stable(ctl) |-> irq_pin_first_o == !ctl[2])
        else $error("disabled first pin active");
    chk_idle_second: assert property (
        !ctl[7] && $stable(ctl) |-> irq_pin_second_o == !ctl[6])
        else $error("disabled second pin active");
    chk_short_pulse: assert property (
        $fell(irq_pin_first_o) && ctl[3:0] == 4'hd && ctl == $past(ctl, 2)
        |-> hi1 == SHORT_CYCLES)
        else $error("short pulse length wrong");
    chk_long_pulse: assert property (
        $fell(irq_pin_first_o) && ctl[3:0] == 4'he && ctl == $past(ctl, 2)
        |-> hi1 == LONG_CYCLES)
        else $error("long pulse length wrong");
    chk_latch_hold: assert property (
        irq_pin_first_o && ctl[3:0] == 4'hc && $stable(ctl)
        && !first_src_clear_i && !$past(first_src_clear_i)
        |=> irq_pin_first_o)
        else $error("latched first pin dropped");
    chk_latch_release: assert property (
        $fell(irq_pin_second_o) && ctl[7:4] == 4'hc && ctl == $past(ctl, 2)
        |-> second_src_clear_o || $past(second_src_clear_o))
        else $error("latched second pin dropped");
endmodule // irq_router_monitor
bind irq_pin_router irq_router_monitor #(
    .SHORT_CYCLES(SHORT_CYCLES), .LONG_CYCLES(LONG_CYCLES)
) u_mon (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i),
    .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o),
    .first_src_clear_i(first_src_clear_i),
    .second_src_clear_o(second_src_clear_o),
    .irq_pin_first_o(irq_pin_first_o), .irq_pin_second_o(irq_pin_second_o)
);
`default_nettype wire

//--- tb/tb_irq_pin_router.sv
// self-checking bench for the interrupt pin router
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin \
    total_checks++; \
    if ((g) !== (e)) begin \
        err_count++; \
        $display("Error %s expected %h seen %h", n, e, g); \
    end \
end
module tb_irq_pin_router;
    typedef struct packed {
        logic [7:0] r1, r2, k, m, s;
        logic [5:0] d;
        logic [1:0] e;
    } row_t;
    row_t rows [8] = '{
        {8'hff, 8'h00, 8'hc0, 8'h3f, 8'h80, 6'h00, 2'h1},
        {8'hff, 8'h00, 8'hc0, 8'h3f, 8'h01, 6'h00, 2'h0},
        {8'h01, 8'h01, 8'h01, 8'h3f, 8'h01, 6'h00, 2'h3},
        {8'h20, 8'h10, 8'h30, 8'h3f, 8'h20, 6'h20, 2'h1},
        {8'h20, 8'h10, 8'h30, 8'h1f, 8'h30, 6'h20, 2'h0},
        {8'h20, 8'h10, 8'h30, 8'h3f, 8'h10, 6'h01, 2'h2},
        {8'h0f, 8'hf0, 8'hff, 8'h3f, 8'h0c, 6'h00, 2'h1},
        {8'h00, 8'hff, 8'hff, 8'h3f, 8'hff, 6'h3f, 2'h2}};
    logic [15:0] rst_tab [7] = '{16'h4544, 16'h46ff, 16'h4700, 16'h48c0,
        16'h493f, 16'h3d00, 16'h0000};
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_write_i = 1'b0;
    logic reg_read_i = 1'b0;
    logic [7:0] src = 8'h00;
    logic [5:0] dir = 6'h00;
    logic first_src_clear_i = 1'b0;
    logic hclr = 1'b0;
    logic [7:0] reg_rdata_o;
    logic second_src_clear_o, irq_pin_first_o, irq_pin_second_o;
    logic [1:0] pins;
    logic [15:0] busy;
    int err_count = 0;
    int total_checks = 0;
    assign pins = {irq_pin_second_o, irq_pin_first_o};
    always #5 clk_i = ~clk_i;
    irq_pin_router #(.SHORT_CYCLES(4), .LONG_CYCLES(16)) u_dut (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i),
        .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o),
        .buffer_full_i(src[7]), .watermark_i(src[6]),
        .wakeup_dir_i(src[5] ? dir : 6'h00),
        .backsleep_dir_i(src[4] ? dir : 6'h00),
        .aux_two_ready_i(src[3]), .aux_one_ready_i(src[2]),
        .accel_temp_ready_i(src[1]), .gyro_ready_i(src[0]),
        .first_src_clear_i(first_src_clear_i),
        .second_src_clear_o(second_src_clear_o),
        .irq_pin_first_o(irq_pin_first_o),
        .irq_pin_second_o(irq_pin_second_o));
    irq_host_sampler u_host (.clk_i(clk_i), .pin_i(irq_pin_first_o),
        .idle_i(1'b0), .clr_i(hclr), .busy_o(busy));
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_write_i = 1'b1;
        @(negedge clk_i);
        reg_write_i = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk_i);
        reg_addr_i = a;
        reg_read_i = 1'b1;
        @(negedge clk_i);
        reg_read_i = 1'b0;
        `CHK("read data", e, reg_rdata_o)
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #200000;
        err_count++;
        test_done();
    end
    initial begin
        repeat (2) @(negedge clk_i);
        rst_b_i = 1'b1;
        wr(8'h45, 8'hff);
        foreach (rows[i]) begin
            wr(8'h46, rows[i].r1);
            wr(8'h47, rows[i].r2);
            wr(8'h48, rows[i].k);
            wr(8'h49, rows[i].m);
            src = rows[i].s;
            dir = rows[i].d;
            repeat (2) @(negedge clk_i);
            `CHK("pins", rows[i].e, pins)
        end
        $display("routing table done");
        wr(8'h49, 8'hff);
        rd(8'h49, 8'h3f);
        wr(8'h46, 8'hff);
        wr(8'h45, 8'h0b);
        src = 8'h80;
        repeat (2) @(negedge clk_i);
        `CHK("low polarity", 2'b10, pins)
        src = 8'h00;
        repeat (2) @(negedge clk_i);
        `CHK("low idle", 2'b11, pins)
        $display("polarity done");
        for (int j = 0; j < 2; j++) begin
            wr(8'h45, j ? 8'h0e : 8'h0d);
            hclr = 1'b1;
            @(negedge clk_i);
            hclr = 1'b0;
            src = 8'h01;
            @(negedge clk_i);
            src = 8'h00;
            repeat (40) @(negedge clk_i);
            `CHK("pulse", j ? 16'h0010 : 16'h0004, busy)
        end
        $display("pulse done");
        first_src_clear_i = 1'b1;
        @(negedge clk_i);
        first_src_clear_i = 1'b0;
        rd(8'h3d, 8'h00);
        wr(8'h45, 8'hcc);
        repeat (2) @(negedge clk_i);
        `CHK("latch idle", 2'b00, pins)
        src = 8'h01;
        @(negedge clk_i);
        src = 8'h00;
        repeat (4) @(negedge clk_i);
        `CHK("latched", 2'b11, pins)
        first_src_clear_i = 1'b1;
        @(negedge clk_i);
        first_src_clear_i = 1'b0;
        repeat (3) @(negedge clk_i);
        `CHK("first release", 2'b10, pins)
        rd(8'h3d, 8'h00);
        repeat (3) @(negedge clk_i);
        `CHK("second release", 2'b00, pins)
        $display("latch done");
        rst_b_i = 1'b0;
        @(negedge clk_i);
        `CHK("reset pins", 2'b00, pins)
        rst_b_i = 1'b1;
        foreach (rst_tab[i]) begin
            rd(rst_tab[i][15:8], rst_tab[i][7:0]);
        end
        $display("reset done");
        test_done();
    end
endmodule // tb_irq_pin_router
`default_nettype wire
